// ==== rtl/fts_map.vh ====
/*
  Constants for the trap-state and feature identification registers:
  register selector codes, field positions, reset values and fixed
  feature values. Definitions only; included by the design files.
*/
`ifndef FTS_MAP_VH
`define FTS_MAP_VH

// Register selector codes carried by the transfer's register field
`define FTS_SEL_TRAP      4'h8
`define FTS_SEL_FAULT     4'h9
`define FTS_SEL_PRIOR     4'ha
`define FTS_SEL_FEAT0     4'h7
`define FTS_SEL_FEAT1     4'h6

// Trap state register bit positions
`define FTS_BIT_PEND      31
`define FTS_BIT_ENABLE    30
`define FTS_BIT_SLOT2     28
`define FTS_LANE_HI       10
`define FTS_LANE_LO       8
`define FTS_BIT_INPUT     7
`define FTS_BIT_SMALL     3
`define FTS_BIT_LARGE     2
`define FTS_BIT_BADOP     0

// Writable bits of the trap state register; reserved bits stay zero
`define FTS_TRAP_WMASK    32'hd000078d

// Status/control bits this block observes
`define FTS_CTL_TINY0     24
`define FTS_CTL_CANON     25
`define FTS_CTL_RM_HI     23
`define FTS_CTL_RM_LO     22
`define FTS_CTL_LARGE_EN  10
`define FTS_CTL_BADOP_EN  8

// Reset values
`define FTS_TRAP_RST      32'h00000000
`define FTS_FAULT_RST     32'hee000a00
`define FTS_PRIOR_RST     32'h00000000
`define FTS_RDATA_RST     32'h00000000

// Register specifier fields retargeted in a vector trap
`define FTS_DST_HI        15
`define FTS_DST_LO        12
`define FTS_SRC_HI        19
`define FTS_SRC_LO        16

// Condition field forced into saved instructions
`define FTS_COND_HI       31
`define FTS_COND_LO       28
`define FTS_COND_ALWAYS   4'he

// Lane count code for zero remaining iterations
`define FTS_LANE_NONE     3'h7

// Feature register 0 low fields and support codes, register 1 value, nearest mode
`define FTS_FEAT0_LOW     28'h1111111
`define FTS_SUPPORT_NONE  4'h0
`define FTS_SUPPORT_REQ   4'h1
`define FTS_FEAT1_VAL     32'h00000000
`define FTS_RM_NEAREST    2'h0

`endif

// ==== rtl/fts_op_rewrite.v ====
/*
  Rewrites a captured instruction word before it is stored in a saved
  slot: forces the always condition and, for short-vector operations,
  steers the destination and first source specifiers to the trapping iteration.
  Assumes the caller supplies the iteration offset already scaled by
  the vector stride. Purely combinational.
*/
`timescale 1ns/1ps
`include "fts_map.vh"

module fts_op_rewrite
(
  op_in,
  is_vector,
  iter_step,
  op_out
);
  input  wire [31:0] op_in;
  input  wire        is_vector;
  input  wire [3:0]  iter_step;
  output reg  [31:0] op_out;

  // Step a 4-bit specifier inside its bank of eight (wraps in bank)
  function [3:0] fts_step;
    input [3:0] spec;
    input [3:0] step;
    begin
      fts_step = {spec[3], spec[2:0] + step[2:0]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Destination in [15:12], sources in [19:16] (first) and [3:0]
  always @*
  begin
    op_out = op_in;
    op_out[`FTS_COND_HI:`FTS_COND_LO] = `FTS_COND_ALWAYS;
    if (is_vector)
    begin
      op_out[`FTS_DST_HI:`FTS_DST_LO] =
        fts_step(op_in[`FTS_DST_HI:`FTS_DST_LO], iter_step);
      op_out[`FTS_SRC_HI:`FTS_SRC_LO] =
        fts_step(op_in[`FTS_SRC_HI:`FTS_SRC_LO], iter_step);
    end
  end

endmodule

// ==== rtl/fts_trap_regs.v ====
/*
  Trap-state, saved-instruction and feature identification registers
  of a floating-point coprocessor. Register transfers arrive from the
  host core on the same clock; detection signals come from the
  arithmetic pipelines on the same clock, so no synchronisers.
  Assumes the core issues at most one transfer per cycle and holds
  the mode word steady around a trap.
*/
// How it works
// - Exception entry sets trap pending until cleared
// - Bit 30 enables unit, reset clears it
// - Second slot valid flag set on capture with a prior word
// - Lane field loads remaining count, 111 zero
// - Input flag: subnormal without flush, NaN without canonical
// - Underflow flag needs flush mode off
// - Overflow flag needs trap enable, not fast
// - Invalid flag needs trap enable, not fast
// - Capture faulting and prior instruction words
// - Saved slots reachable only when privileged
// - Saved words get always condition
// - Faulting word's destination and first source name trapping iteration
// - Feature registers read-only, unprivileged reads gated by enable
// - Feature register 0 fields below support level read one
// - Support field zero only for easy modes
// - Feature register 1 reads all zero
// - Flush mode comes from control bit 24
// - Canonical NaN from control bit 25
// - Unprivileged forbidden access raises undefined
`timescale 1ns/1ps
`include "fts_map.vh"

module fts_trap_regs
(
  clk,
  nrst,
  xfer_valid,
  xfer_write,
  xfer_sel,
  xfer_wdata,
  xfer_priv,
  xfer_rdata,
  xfer_done,
  xfer_undef,
  ctl_word,
  fast_nonbouncing_mode,
  trap_event,
  trap_op,
  trap_has_prior,
  prior_op,
  trap_is_vector,
  iter_step,
  remaining_lane_count,
  op_subnormal,
  op_nan,
  may_underflow,
  may_overflow,
  may_be_invalid,
  unit_enabled,
  trap_pending_flag
);
  input  wire        clk;
  input  wire        nrst;
  input  wire        xfer_valid;
  input  wire        xfer_write;
  input  wire [3:0]  xfer_sel;
  input  wire [31:0] xfer_wdata;
  input  wire        xfer_priv;
  output wire [31:0] xfer_rdata;
  output wire        xfer_done;
  output wire        xfer_undef;
  input  wire [31:0] ctl_word;
  input  wire        fast_nonbouncing_mode;
  input  wire        trap_event;
  input  wire [31:0] trap_op;
  input  wire        trap_has_prior;
  input  wire [31:0] prior_op;
  input  wire        trap_is_vector;
  input  wire [3:0]  iter_step;
  input  wire [2:0]  remaining_lane_count;
  input  wire        op_subnormal;
  input  wire        op_nan;
  input  wire        may_underflow;
  input  wire        may_overflow;
  input  wire        may_be_invalid;
  output wire        unit_enabled;
  output wire        trap_pending_flag;

  reg  [31:0] trap_state_reg;
  reg  [31:0] trap_state_next;
  reg  [31:0] faulting_op_reg;
  reg  [31:0] faulting_op_next;
  reg  [31:0] prior_op_reg;
  reg  [31:0] prior_op_next;
  reg  [31:0] rdata_reg;
  reg         allowed;
  reg         known;
  wire [31:0] fault_fixed;
  wire [31:0] prior_fixed;
  wire [31:0] feature_id0_reg;
  wire [31:0] feature_id1_reg;
  wire        tiny_to_zero_mode;
  wire        canonical_nan_mode;
  wire        large_result_trap_on;
  wire        bad_op_trap_on;
  wire        round_nearest;
  wire        wr_ok;
  wire        input_trap_flag;
  wire        small_result_flag;
  wire        large_result_flag;
  wire        bad_operation_flag;
  wire [4:0]  pick;

  ////////////////////////////////////////////////////////////////////
  // Mode bits taken from the status/control word
  // Taken live: the core serialises control writes around traps
  // flush mode bit
  assign tiny_to_zero_mode    = ctl_word[`FTS_CTL_TINY0];
  assign canonical_nan_mode   = ctl_word[`FTS_CTL_CANON];
  assign large_result_trap_on = ctl_word[`FTS_CTL_LARGE_EN];
  assign bad_op_trap_on       = ctl_word[`FTS_CTL_BADOP_EN];
  assign round_nearest        =
    (ctl_word[`FTS_CTL_RM_HI:`FTS_CTL_RM_LO] == `FTS_RM_NEAREST);

  assign unit_enabled      = trap_state_reg[`FTS_BIT_ENABLE];
  assign trap_pending_flag = trap_state_reg[`FTS_BIT_PEND];
  assign xfer_rdata        = rdata_reg;

  ////////////////////////////////////////////////////////////////////
  // Cause conditions, qualified by the current modes
  // Fast mode promises no bounce, so it masks the enabled causes
  // input trap condition
  assign input_trap_flag = (op_subnormal & ~tiny_to_zero_mode) |
                           (op_nan & ~canonical_nan_mode);
  assign small_result_flag = may_underflow & ~tiny_to_zero_mode;
  assign large_result_flag = may_overflow & large_result_trap_on &
                             ~fast_nonbouncing_mode;
  assign bad_operation_flag = may_be_invalid & bad_op_trap_on &
                              ~fast_nonbouncing_mode;

  ////////////////////////////////////////////////////////////////////
  // Feature identification values are wiring; only the support level varies
  // Support level follows the live mode bits, not a snapshot
  // fields below the support level read one
  assign feature_id0_reg = {
    (tiny_to_zero_mode & canonical_nan_mode & round_nearest) ?
      `FTS_SUPPORT_NONE : `FTS_SUPPORT_REQ,
    `FTS_FEAT0_LOW};
  assign feature_id1_reg = `FTS_FEAT1_VAL;

  ////////////////////////////////////////////////////////////////////
  // Saved words are rewritten on the way in, not on read-back
  fts_op_rewrite u_fault_fix
  (
    .op_in     (trap_op),
    .is_vector (trap_is_vector),
    .iter_step (iter_step),
    .op_out    (fault_fixed)
  );

  fts_op_rewrite u_prior_fix
  (
    .op_in     (prior_op),
    .is_vector (1'h0),
    .iter_step (4'h0),
    .op_out    (prior_fixed)
  );

  ////////////////////////////////////////////////////////////////////
  // Selector to one-hot register pick; zero for selectors not here
  function [4:0] fts_pick;
    input [3:0] sel;
    begin
      case (sel)
        `FTS_SEL_TRAP:  fts_pick = 5'h01;
        `FTS_SEL_FAULT: fts_pick = 5'h02;
        `FTS_SEL_PRIOR: fts_pick = 5'h04;
        `FTS_SEL_FEAT0: fts_pick = 5'h08;
        `FTS_SEL_FEAT1: fts_pick = 5'h10;
        default:        fts_pick = 5'h00;
      endcase
    end
  endfunction

  assign pick = fts_pick(xfer_sel);

  // Access check per selector. Unknown selectors are refused too, so
  // a stray transfer can never complete silently.
  always @*
  begin
    allowed = 1'h0;
    known   = |pick;
    if (|pick[2:0])
      allowed = xfer_priv;
    if (|pick[4:3])
      allowed = (xfer_priv | unit_enabled) & ~xfer_write;
  end

  assign xfer_undef = xfer_valid & ~(allowed & known);
  assign xfer_done  = xfer_valid & allowed & known;
  assign wr_ok      = xfer_done & xfer_write;

  ////////////////////////////////////////////////////////////////////
  // Next state. Software write lands first, then hardware capture, so
  // a trap in the same cycle as a clear still leaves its flags set.
  always @*
  begin
    trap_state_next  = trap_state_reg;
    faulting_op_next = faulting_op_reg;
    prior_op_next    = prior_op_reg;
    if (wr_ok)
    begin
      case (xfer_sel)
        `FTS_SEL_TRAP:
          trap_state_next = xfer_wdata & `FTS_TRAP_WMASK;
        `FTS_SEL_FAULT:
          faulting_op_next = xfer_wdata;
        `FTS_SEL_PRIOR:
          prior_op_next = xfer_wdata;
        default:
          trap_state_next = trap_state_reg;
      endcase
    end
    if (trap_event)
    begin
      trap_state_next[`FTS_BIT_PEND] = 1'h1;
      // Scalar traps have no lanes left and report the zero code
      // remaining lane count
      trap_state_next[`FTS_LANE_HI:`FTS_LANE_LO] =
        trap_is_vector ? remaining_lane_count : `FTS_LANE_NONE;
      // Cause flags are sticky; only a software write or reset clears them
      trap_state_next[`FTS_BIT_INPUT] =
        trap_state_next[`FTS_BIT_INPUT] | input_trap_flag;
      trap_state_next[`FTS_BIT_SMALL] =
        trap_state_next[`FTS_BIT_SMALL] | small_result_flag;
      trap_state_next[`FTS_BIT_LARGE] =
        trap_state_next[`FTS_BIT_LARGE] | large_result_flag;
      trap_state_next[`FTS_BIT_BADOP] =
        trap_state_next[`FTS_BIT_BADOP] | bad_operation_flag;
      faulting_op_next = fault_fixed;
      if (trap_has_prior)
      begin
        trap_state_next[`FTS_BIT_SLOT2] = 1'h1;
        prior_op_next = prior_fixed;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State registers
  // Prior slot resets to zero so an unused slot reads a known value
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      trap_state_reg  <= `FTS_TRAP_RST;
      faulting_op_reg <= `FTS_FAULT_RST;
      prior_op_reg    <= `FTS_PRIOR_RST;
    end
    else
    begin
      trap_state_reg  <= trap_state_next;
      faulting_op_reg <= faulting_op_next;
      prior_op_reg    <= prior_op_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data registered; holds last value when no read completes
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata_reg <= `FTS_RDATA_RST;
    else if (xfer_done & ~xfer_write)
    begin
      // Default is unreachable: unknown selectors never complete
      case (xfer_sel)
        `FTS_SEL_TRAP:  rdata_reg <= trap_state_reg;
        `FTS_SEL_FAULT: rdata_reg <= faulting_op_reg;
        `FTS_SEL_PRIOR: rdata_reg <= prior_op_reg;
        `FTS_SEL_FEAT0: rdata_reg <= feature_id0_reg;
        `FTS_SEL_FEAT1: rdata_reg <= feature_id1_reg;
        default:        rdata_reg <= `FTS_RDATA_RST;
      endcase
    end
  end

endmodule

// ==== verif/fts_trap_regs_chk.sv ====
/* Assertions on transfers, privilege gating and trap flags.
   Assumes one clock and nrst active low; bound to fts_trap_regs. */
`timescale 1ns/1ps
`include "fts_map.vh"
module fts_chk
(
  input logic        clk,
  input logic        nrst,
  input logic        xfer_valid,
  input logic        xfer_write,
  input logic [3:0]  xfer_sel,
  input logic [31:0] xfer_wdata,
  input logic        xfer_priv,
  input logic [31:0] xfer_rdata,
  input logic        xfer_done,
  input logic        xfer_undef,
  input logic        trap_event,
  input logic        unit_enabled,
  input logic        trap_pending_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Accepted reads, accepted trap state writes and any feature register transfer
  wire rd  = xfer_done && !xfer_write;
  wire wr8 = xfer_done && xfer_write && xfer_sel == 4'h8;
  wire ftr = xfer_valid && (xfer_sel == 4'h6 || xfer_sel == 4'h7);
  ////////////////////////////////////////
  chk_pend_set: assert property (trap_event |=> trap_pending_flag)
    else $error("pending flag not set by trap");
  chk_pend_hold: assert property
    (trap_pending_flag && !wr8 |=> trap_pending_flag)
    else $error("pending flag dropped without write");
  chk_enable_wr: assert property
    (wr8 |=> unit_enabled == $past(xfer_wdata[30]))
    else $error("enable bit not taken from write");
  chk_slot_priv: assert property
    (xfer_valid && !xfer_priv && xfer_sel inside {4'h8, 4'h9, 4'ha}
     |-> xfer_undef && !xfer_done)
    else $error("unprivileged slot access accepted");
  chk_feat_gate: assert property
    (ftr && !xfer_write && (xfer_priv || unit_enabled) |-> xfer_done)
    else $error("feature read refused");
  chk_feat_ro: assert property (ftr && xfer_write |-> xfer_undef)
    else $error("feature write accepted");
  chk_refuse_no_write: assert property
    (xfer_undef |=> $stable(unit_enabled))
    else $error("refused transfer changed enable");
  chk_feat1_zero: assert property
    (rd && xfer_sel == 4'h6 |=> xfer_rdata == 32'h0)
    else $error("feature1 not zero");
  chk_feat0_ones: assert property
    (rd && xfer_sel == 4'h7 |=> xfer_rdata[27:0] == 28'h1111111)
    else $error("feature0 low fields wrong");
  chk_resv_zero: assert property
    (rd && xfer_sel == 4'h8 |=> (xfer_rdata & ~`FTS_TRAP_WMASK) == 32'h0)
    else $error("reserved trap bits not zero");
endmodule
bind fts_trap_regs fts_chk u_chk (.clk, .nrst, .xfer_valid, .xfer_write,
  .xfer_sel, .xfer_wdata, .xfer_priv, .xfer_rdata, .xfer_done,
  .xfer_undef, .trap_event, .unit_enabled, .trap_pending_flag);

// ==== verif/fts_host.sv ====
/* Host core model issuing register transfers to the trap block.
   Assumes inputs are driven at the falling edge of clk. */
`timescale 1ns/1ps
module fts_host
(
  input  logic        clk,
  output logic        xfer_valid,
  output logic        xfer_write,
  output logic [3:0]  xfer_sel,
  output logic [31:0] xfer_wdata,
  output logic        xfer_priv,
  input  logic [31:0] xfer_rdata,
  input  logic        xfer_undef
);
  // Idle bus at time zero
  initial
  begin
    {xfer_valid, xfer_write, xfer_priv} = 3'h0;
    xfer_sel = 4'h0;
    xfer_wdata = 32'h0;
  end
  ////////////////////////////////////////
  // One transfer held across one rising edge; on release valid drops
  // and select and data are inverted so stale values cannot pass for fresh ones
  task xfer(input logic w, input logic [3:0] s, input logic [31:0] d,
            input logic p, output logic [31:0] q, output logic u);
    @(negedge clk);
    {xfer_valid, xfer_write, xfer_priv} = {1'b1, w, p};
    xfer_sel = s;
    xfer_wdata = d;
    #1 u = xfer_undef;
    @(negedge clk);
    xfer_valid = 1'b0;
    xfer_sel = ~s;
    xfer_wdata = ~d;
    q = xfer_rdata;
  endtask
endmodule

// ==== verif/fts_trap_regs_tb_top.sv ====
/* Self-checking bench for fts_trap_regs: reset values, privilege,
   enable, feature fields and trap capture. Assumes fts_host model. */
`timescale 1ns/1ps
module fts_trap_regs_tb_top;
  logic        clk = 0, nrst = 0, fast = 0, trap_event = 0, vec = 0, u;
  logic [31:0] ctl_word = 0, q;
  logic [4:0]  cause = 0;
  logic [2:0]  lanes = 3'h2;
  logic [3:0]  step = 4'h2;
  int          n_fail = 0, checked = 0, cyc = 0;
  wire         xfer_valid, xfer_write, xfer_priv, xfer_done, xfer_undef;
  wire         unit_enabled, trap_pending_flag;
  wire [3:0]   xfer_sel;
  wire [31:0]  xfer_wdata, xfer_rdata;
  fts_host host (.clk, .xfer_valid, .xfer_write, .xfer_sel, .xfer_wdata,
    .xfer_priv, .xfer_rdata, .xfer_undef);
  fts_trap_regs DUT (.clk, .nrst, .xfer_valid, .xfer_write, .xfer_sel,
    .xfer_wdata, .xfer_priv, .xfer_rdata, .xfer_done, .xfer_undef,
    .ctl_word, .fast_nonbouncing_mode(fast), .trap_event,
    .trap_op(32'h0307e1a5), .trap_has_prior(vec),
    .prior_op(32'h5a5a5a5a), .trap_is_vector(vec), .iter_step(step),
    .remaining_lane_count(lanes), .op_subnormal(cause[4]),
    .op_nan(cause[3]), .may_underflow(cause[2]), .may_overflow(cause[1]),
    .may_be_invalid(cause[0]), .unit_enabled, .trap_pending_flag);
  // 10 MHz clock and a hang limit well above the run length
  always #50 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      stop_test;
    end
  end
  ////////////////////////////////////////
  task stop_test;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Privileged read or write, or a refused transfer, through the host model
  task rd(input logic [3:0] s, input logic [31:0] e);
    host.xfer(1'b0, s, 32'h0, 1'b1, q, u);
    chk($sformatf("reg %h", s), q, e);
  endtask
  task wr(input logic [3:0] s, input logic [31:0] d);
    host.xfer(1'b1, s, d, 1'b1, q, u);
  endtask
  task refuse(input logic w, input logic [3:0] s, input logic p);
    host.xfer(w, s, 32'hffffffff, p, q, u);
    chk("undef", {31'h0, u}, 32'h1);
  endtask
  // One trap, check state, then handler clears it
  task trap_case(input logic [31:0] c, input logic [4:0] cz,
                 input logic fst, v, input logic [31:0] e);
    @(negedge clk);
    {ctl_word, cause, fast, vec, trap_event} = {c, cz, fst, v, 1'b1};
    @(negedge clk);
    trap_event = 1'b0;
    chk("pending", {31'h0, trap_pending_flag}, 32'h1);
    rd(4'h8, e);
    wr(4'h8, 32'h40000000);
    chk("cleared", {31'h0, trap_pending_flag}, 32'h0);
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clk);
    @(negedge clk) nrst = 1'b1;
    rd(4'h8, 32'h0);
    rd(4'h9, 32'hee000a00);
    rd(4'ha, 32'h0);
    rd(4'h7, 32'h11111111);
    rd(4'h6, 32'h0);
    $display("test reset values done");
    refuse(1'b0, 4'h8, 1'b0);
    refuse(1'b0, 4'h9, 1'b0);
    refuse(1'b0, 4'ha, 1'b0);
    refuse(1'b1, 4'h8, 1'b0);
    rd(4'h8, 32'h0);
    refuse(1'b0, 4'h7, 1'b0);
    refuse(1'b1, 4'h7, 1'b1);
    refuse(1'b1, 4'h6, 1'b1);
    refuse(1'b0, 4'h3, 1'b1);
    $display("test refusals done");
    wr(4'h8, 32'hffffffff);
    rd(4'h8, 32'hd000078d);
    wr(4'h8, 32'h40000000);
    chk("enable", {31'h0, unit_enabled}, 32'h1);
    host.xfer(1'b0, 4'h7, 32'h0, 1'b0, q, u);
    chk("user feature0", q, 32'h11111111);
    @(negedge clk) ctl_word = 32'h03000000;
    rd(4'h7, 32'h01111111);
    @(negedge clk) ctl_word = 32'h03400000;
    rd(4'h7, 32'h11111111);
    $display("test enable and features done");
    trap_case(32'h00000500, 5'h17, 1'b0, 1'b1, 32'hd000028d);
    rd(4'h9, 32'he30181a5);
    rd(4'ha, 32'hea5a5a5a);
    wr(4'h9, 32'hee000a00);
    rd(4'h9, 32'hee000a00);
    trap_case(32'h03000000, 5'h1f, 1'b0, 1'b0, 32'hc0000700);
    rd(4'h9, 32'he307e1a5);
    trap_case(32'h01000400, 5'h0f, 1'b1, 1'b0, 32'hc0000780);
    trap_case(32'h02000100, 5'h0f, 1'b0, 1'b0, 32'hc0000709);
    @(negedge clk) {lanes, step} = {3'h5, 4'h7};
    trap_case(32'h00000000, 5'h00, 1'b0, 1'b1, 32'hd0000500);
    rd(4'h9, 32'he306d1a5);
    $display("test trap capture done");
    @(negedge clk) nrst = 1'b0;
    @(negedge clk) nrst = 1'b1;
    chk("reset enable", {31'h0, unit_enabled}, 32'h0);
    rd(4'h8, 32'h0);
    rd(4'h9, 32'hee000a00);
    $display("test mid-run reset done");
    stop_test;
  end
endmodule
